// ---- verilog/pieb_pkg.sv ----
package pieb_pkg;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [11:0] ADDR_FLAG_0 = 12'h70c;
  localparam logic [11:0] ADDR_FLAG_1 = 12'h70d;
  localparam logic [11:0] ADDR_FLAG_2 = 12'h70e;
  localparam logic [11:0] ADDR_ENABLE_7 = 12'h71d;
  localparam logic [11:0] ADDR_ENABLE_8 = 12'h71e;
  localparam logic [11:0] ADDR_ENABLE_0 = 12'h716;
  localparam logic [11:0] ADDR_ENABLE_1 = 12'h717;
  localparam logic [11:0] ADDR_ENABLE_2 = 12'h718;
  localparam logic [11:0] ADDR_CORE_CTRL = 12'h7f0;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int F0_EXT_PIN = 0;
  localparam int F0_CHANGE_SUM = 4;
  localparam int F0_TIMER_WRAP = 5;
  localparam int F1_CONV_DONE = 0;
  localparam int F1_CONV_THRESH = 1;
  localparam int F1_CLK_SWITCH = 6;
  localparam int F1_OSC_FAIL = 7;
  localparam int F2_CMP_A = 0;
  localparam int F2_CMP_B = 1;
  localparam int F2_ZERO_CROSS = 6;
  localparam int CTRL_GLOBAL = 7;
  localparam int CTRL_GATE = 6;

  // writable bit masks; other positions read as zero, except the change summary read at flag register 0 bit 4
  localparam logic [7:0] MASK_FLAG_0 = 8'h21;
  localparam logic [7:0] MASK_FLAG_1 = 8'hc3;
  localparam logic [7:0] MASK_FLAG_2 = 8'h43;
  localparam logic [7:0] MASK_ENABLE_0 = 8'h31;
  localparam logic [7:0] MASK_ENABLE_1 = 8'hc3;
  localparam logic [7:0] MASK_ENABLE_2 = 8'h43;
  localparam logic [7:0] MASK_ENABLE_7 = 8'h33;
  localparam logic [7:0] MASK_ENABLE_8 = 8'h07;
  localparam logic [7:0] MASK_CORE_CTRL = 8'hc0;

  localparam logic [7:0] RESET_VALUE = 8'h00;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] flag_0;
    logic [7:0] flag_1;
    logic [7:0] flag_2;
    logic [7:0] enable_0;
    logic [7:0] enable_1;
    logic [7:0] enable_2;
    logic [7:0] enable_7;
    logic [7:0] enable_8;
    logic [7:0] core_ctrl;
    logic [7:0] rd_data;
    logic irq;
  } pieb_state_t;

endpackage

// ---- verilog/pieb_bank.sv ----
// Overview of operation
// R1: peripheral-gated sources reach the core only while the peripheral gate is set
// R2: flags set on their events regardless of any enable bit
// R3: software clears stale flags before enabling; the bank does not enforce it
// R4: change summary flag is read-only OR of all port change flags
// R5: first timer wrap sets flag register 0 bit 5, sticky until cleared
// R6: external pin event sets flag register 0 bit 0
// R7: oscillator fail event sets flag register 1 bit 7
// R8: clock switch ready sets flag register 1 bit 6
// R9: converter threshold bit 1 and completion bit 0 of flag register 1
// R10: zero-cross event sets flag register 2 bit 6
// R11: comparator events set flag register 2 bits 0 and 1
// R12: enable register 7 holds memory, oscillator and waveform enables, reset 0
// R13: enable register 8 holds measurement timer enables, reset 0
// R14: flag registers 0..2 at consecutive addresses; unused bits read zero
// R15: enable bits written 1 enable, 0 disable, all reset to 0
// R16: enable register 0 sources need only the global enable
// R17: event strobe sets a flag; write 0 clears; event wins over clear
// R18: request is OR of flag AND enable, gated by global; peripheral gate gates all but enable register 0 sources
//
// The strobed register port is this design's own decision.
module pieb_bank
  import pieb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [pieb_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [pieb_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [pieb_pkg::DATA_W-1:0] bus_rdata,
  input wire logic first_timer_wrap_evt,
  input wire logic [4:0] port_change_flags,
  input wire logic ext_pin_evt,
  input wire logic osc_fail_evt,
  input wire logic clk_switch_evt,
  input wire logic conv_done_evt,
  input wire logic conv_threshold_evt,
  input wire logic zero_cross_evt,
  input wire logic [1:0] comparator_evt,
  input wire logic [7:0] high_peripheral_req,
  output logic irq_req,
  output logic global_irq_enable,
  output logic peripheral_irq_gate
);
  import pieb_pkg::*;

  pieb_state_t cur;
  pieb_state_t next_state;
  logic change_summary_flag;
  logic [7:0] flag_0_view;
  logic [7:0] evt_0;
  logic [7:0] evt_1;
  logic [7:0] evt_2;
  logic low_req;
  logic periph_req;

  // -------------------------------------------------------------------------
  // event vectors
  // -------------------------------------------------------------------------
  assign change_summary_flag = |port_change_flags; // [R4]
  assign flag_0_view = (cur.flag_0 & MASK_FLAG_0) | ({7'h00, change_summary_flag} << F0_CHANGE_SUM);

  always_comb
  begin
    evt_0 = 8'h00;
    evt_1 = 8'h00;
    evt_2 = 8'h00;
    evt_0[F0_TIMER_WRAP] = first_timer_wrap_evt; // [R5]
    evt_0[F0_EXT_PIN] = ext_pin_evt; // [R6]
    evt_1[F1_OSC_FAIL] = osc_fail_evt; // [R7]
    evt_1[F1_CLK_SWITCH] = clk_switch_evt; // [R8]
    evt_1[F1_CONV_THRESH] = conv_threshold_evt; // [R9]
    evt_1[F1_CONV_DONE] = conv_done_evt; // [R9]
    evt_2[F2_ZERO_CROSS] = zero_cross_evt; // [R10]
    evt_2[F2_CMP_B] = comparator_evt[1]; // [R11]
    evt_2[F2_CMP_A] = comparator_evt[0]; // [R11]
  end

  // -------------------------------------------------------------------------
  // request qualification
  // -------------------------------------------------------------------------
  // enable register 0 sources bypass the peripheral gate
  assign low_req = |(flag_0_view & cur.enable_0); // [R16]
  // lower-level high peripheral requests arrive pre-flagged; enable 7/8 gate them
  assign periph_req = |(cur.flag_1 & cur.enable_1)
    | |(cur.flag_2 & cur.enable_2)
    | |(high_peripheral_req & cur.enable_7 & MASK_ENABLE_7)
    | |(high_peripheral_req[2:0] & cur.enable_8[2:0]);

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_state = cur;
    next_state.rd_data = RESET_VALUE;
    if (bus_wr)
    begin
      unique case (bus_addr)
        ADDR_FLAG_0: next_state.flag_0 = bus_wdata & MASK_FLAG_0; // [R17]
        ADDR_FLAG_1: next_state.flag_1 = bus_wdata & MASK_FLAG_1; // [R17]
        ADDR_FLAG_2: next_state.flag_2 = bus_wdata & MASK_FLAG_2; // [R17]
        ADDR_ENABLE_0: next_state.enable_0 = bus_wdata & MASK_ENABLE_0; // [R15]
        ADDR_ENABLE_1: next_state.enable_1 = bus_wdata & MASK_ENABLE_1; // [R15]
        ADDR_ENABLE_2: next_state.enable_2 = bus_wdata & MASK_ENABLE_2; // [R15]
        ADDR_ENABLE_7: next_state.enable_7 = bus_wdata & MASK_ENABLE_7; // [R12] [R15]
        ADDR_ENABLE_8: next_state.enable_8 = bus_wdata & MASK_ENABLE_8; // [R13] [R15]
        ADDR_CORE_CTRL: next_state.core_ctrl = bus_wdata & MASK_CORE_CTRL;
        default: ;
      endcase
    end
    // events override any same-cycle software clear, enables ignored
    next_state.flag_0 = next_state.flag_0 | evt_0; // [R2] [R17]
    next_state.flag_1 = next_state.flag_1 | evt_1; // [R2] [R17]
    next_state.flag_2 = next_state.flag_2 | evt_2; // [R2] [R17]
    if (bus_rd)
    begin
      unique case (bus_addr)
        ADDR_FLAG_0: next_state.rd_data = flag_0_view; // [R4] [R14]
        ADDR_FLAG_1: next_state.rd_data = cur.flag_1 & MASK_FLAG_1; // [R14]
        ADDR_FLAG_2: next_state.rd_data = cur.flag_2 & MASK_FLAG_2; // [R14]
        ADDR_ENABLE_0: next_state.rd_data = cur.enable_0;
        ADDR_ENABLE_1: next_state.rd_data = cur.enable_1;
        ADDR_ENABLE_2: next_state.rd_data = cur.enable_2;
        ADDR_ENABLE_7: next_state.rd_data = cur.enable_7; // [R12]
        ADDR_ENABLE_8: next_state.rd_data = cur.enable_8; // [R13]
        ADDR_CORE_CTRL: next_state.rd_data = cur.core_ctrl;
        default: next_state.rd_data = RESET_VALUE;
      endcase
    end
    // request follows the registered state one cycle later
    next_state.irq = cur.core_ctrl[CTRL_GLOBAL]
      & (low_req | (cur.core_ctrl[CTRL_GATE] & periph_req)); // [R1] [R18]
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cur <= '0; // [R12] [R13] [R15]
    end
    else
    begin
      cur <= next_state;
    end
  end

  assign bus_rdata = cur.rd_data;
  assign irq_req = cur.irq;
  assign global_irq_enable = cur.core_ctrl[CTRL_GLOBAL];
  assign peripheral_irq_gate = cur.core_ctrl[CTRL_GATE];

endmodule // pieb_bank

// ---- bench/pieb_bank_monitor.sv ----
module pieb_bank_monitor
  import pieb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [pieb_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [pieb_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [pieb_pkg::DATA_W-1:0] bus_rdata,
  input wire logic first_timer_wrap_evt,
  input wire logic [4:0] port_change_flags,
  input wire logic ext_pin_evt,
  input wire logic irq_req,
  input wire logic global_irq_enable,
  input wire logic peripheral_irq_gate
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // bus and request checks
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence rd_f0; bus_rd && bus_addr == ADDR_FLAG_0; endsequence
  sequence wr_e7; bus_wr && bus_addr == ADDR_ENABLE_7; endsequence
  sequence rd_e7; bus_rd && bus_addr == ADDR_ENABLE_7; endsequence
  rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  sum_live_a: assert property (rd_f0 |=> bus_rdata[4] == $past(|port_change_flags))
    else $error("change summary not or of port flags");
  rsvd_zero_a: assert property (rd_f0 |=> (bus_rdata & 8'hce) == 8'h00)
    else $error("unused flag bits not zero");
  wrap_set_a: assert property (first_timer_wrap_evt ##1 rd_f0 |=> bus_rdata[5])
    else $error("timer wrap flag not set");
  ext_set_a: assert property (ext_pin_evt ##1 rd_f0 |=> bus_rdata[0])
    else $error("external pin flag not set");
  ctl_write_a: assert property (bus_wr && bus_addr == ADDR_CORE_CTRL |=>
    {global_irq_enable, peripheral_irq_gate} == $past(bus_wdata[7:6]))
    else $error("control bits not taken from write");
  irq_off_a: assert property (!global_irq_enable |=> !irq_req)
    else $error("request without global enable");
  irq_rise_a: assert property ($rose(irq_req) |-> $past(global_irq_enable))
    else $error("request rose while global enable low");
  en7_back_a: assert property (wr_e7 ##2 rd_e7 |=>
    bus_rdata == ($past(bus_wdata, 3) & MASK_ENABLE_7))
    else $error("enable register 7 readback wrong");
endmodule // pieb_bank_monitor

bind pieb_bank pieb_bank_monitor u_pieb_bank_monitor (.*);

// ---- bench/pieb_src.sv ----
module pieb_src (
  input wire logic ref_clk,
  input wire logic [8:0] kick,
  output logic [8:0] evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // one-cycle peripheral event strobes
  // ----
  always_ff @(posedge ref_clk)
  begin
    evt <= kick;
  end
endmodule // pieb_src

// ---- bench/testbench.sv ----
module testbench
  import pieb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0, sys_rst = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0] bus_wdata = 8'h00, high_peripheral_req = 8'h00, bus_rdata;
  logic [8:0] kick = 9'h000, evt;
  logic [4:0] port_change_flags = 5'h00;
  logic irq_req, global_irq_enable, peripheral_irq_gate;
  int bad_count = 0, compares = 0;
  localparam logic [11:0] map_a [6] = '{ADDR_FLAG_0, ADDR_FLAG_1, ADDR_FLAG_2,
    ADDR_ENABLE_7, ADDR_ENABLE_8, 12'h700};
  localparam logic [7:0] map_m [6] = '{8'h21, 8'hc3, 8'h43, 8'h33, 8'h07, 8'h00};
  localparam logic [11:0] ev_a [9] = '{ADDR_FLAG_0, ADDR_FLAG_0, ADDR_FLAG_1, ADDR_FLAG_1,
    ADDR_FLAG_1, ADDR_FLAG_1, ADDR_FLAG_2, ADDR_FLAG_2, ADDR_FLAG_2};
  localparam logic [7:0] ev_m [9] = '{8'h20, 8'h01, 8'h80, 8'h40, 8'h02, 8'h01,
    8'h40, 8'h01, 8'h02};
  // ----
  // harness
  // ----
  always #20 ref_clk = ~ref_clk;
  pieb_src u_pieb_src (.*);
  pieb_bank u_pieb_bank (.*, .first_timer_wrap_evt(evt[0]), .ext_pin_evt(evt[1]),
    .osc_fail_evt(evt[2]), .clk_switch_evt(evt[3]), .conv_threshold_evt(evt[4]),
    .conv_done_evt(evt[5]), .zero_cross_evt(evt[6]), .comparator_evt(evt[8:7]));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_rd <= 1'h1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'h0;
    #1 chk($sformatf("reg %h", a), e, bus_rdata);
  endtask
  task automatic ev(input int i);
    @(posedge ref_clk);
    kick <= 9'h001 << i;
    @(posedge ref_clk);
    kick <= 9'h000;
  endtask
  task automatic t_map;
    for (int i = 0; i < 6; i++)
    begin
      rd(map_a[i], 8'h00);
      wr(map_a[i], 8'hff);
      rd(map_a[i], map_m[i]);
      wr(map_a[i], 8'h00);
      rd(map_a[i], 8'h00);
    end
  endtask
  task automatic t_events;
    for (int i = 0; i < 9; i++)
    begin
      ev(i);
      rd(ev_a[i], ev_m[i]);
      chk("irq_req", 8'h00, {7'h00, irq_req});
      wr(ev_a[i], 8'h00);
      rd(ev_a[i], 8'h00);
    end
  endtask
  task automatic t_change;
    @(posedge ref_clk);
    port_change_flags <= 5'h10;
    rd(ADDR_FLAG_0, 8'h10);
    wr(ADDR_FLAG_0, 8'h00);
    rd(ADDR_FLAG_0, 8'h10);
    @(posedge ref_clk);
    port_change_flags <= 5'h00;
    rd(ADDR_FLAG_0, 8'h00);
  endtask
  task automatic t_clash;
    // event strobe and software clear reach the bank at the same edge
    fork
      ev(2);
      begin
        @(posedge ref_clk);
        wr(ADDR_FLAG_1, 8'h00);
      end
    join
    rd(ADDR_FLAG_1, 8'h80);
    wr(ADDR_FLAG_1, 8'h00);
    rd(ADDR_FLAG_1, 8'h00);
  endtask
  task automatic t_irq;
    wr(ADDR_FLAG_0, 8'h00);
    wr(ADDR_CORE_CTRL, 8'h80);
    wr(ADDR_ENABLE_0, 8'h20);
    ev(0);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_req", 8'h01, {7'h00, irq_req});
    wr(ADDR_FLAG_0, 8'h00);
    @(posedge ref_clk);
    #1 chk("irq_req", 8'h00, {7'h00, irq_req});
    @(posedge ref_clk);
    high_peripheral_req <= 8'h01;
    wr(ADDR_ENABLE_7, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_req", 8'h00, {7'h00, irq_req});
    wr(ADDR_CORE_CTRL, 8'hc0);
    @(posedge ref_clk);
    #1 chk("irq_req", 8'h01, {7'h00, irq_req});
    wr(ADDR_CORE_CTRL, 8'h40);
    @(posedge ref_clk);
    #1 chk("irq_req", 8'h00, {7'h00, irq_req});
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_map;
    t_events;
    t_change;
    t_clash;
    t_irq;
    end_of_test;
  end
  initial
  begin
    #200000;
    bad_count++;
    end_of_test;
  end
endmodule // testbench
